/* File: rtl/acs_pkg.sv */
// Constants, carriers and state layout for the ADC channel sequencer
package acs_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Channels and data
   localparam int NUM_PINS = 8;
   localparam int NUM_CH = NUM_PINS + 1;
   localparam logic [3:0] TEMP_CH = 4'h8;
   localparam int RES_W = 12;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_HZ = 25_000_000;
   localparam int SAR_CLK_MAX_HZ = 18_000_000;
   // Converter clock is rounded down from the reference so it never exceeds its maximum
   localparam int SAR_DIV = (CLK_HZ + SAR_CLK_MAX_HZ - 1) / SAR_CLK_MAX_HZ;
   localparam int DIV_W = (SAR_DIV > 1) ? $clog2(SAR_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(SAR_DIV - 1);
   localparam logic [7:0] CONV_CLKS = 8'h12;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses; RES_IDX and SMP_IDX are word indices)
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] CHEN_OFS = 12'h004;
   localparam logic [11:0] LIMIT_OFS = 12'h008;
   localparam logic [11:0] STATUS_OFS = 12'h00c;
   localparam logic [11:0] INTSTAT_OFS = 12'h010;
   localparam logic [11:0] INTMASK_OFS = 12'h014;
   localparam logic [5:0] RES_IDX = 6'h10;
   localparam logic [5:0] SMP_IDX = 6'h20;

   // Field positions
   localparam int CTRL_RUN = 0;
   localparam int CTRL_FW = 1;
   localparam int CTRL_GO = 2;
   localparam int CTRL_FWCH_LSB = 4;
   localparam int LIM_HI_LSB = 16;
   localparam int STAT_BUSY = 0;
   localparam int STAT_CH_LSB = 4;
   localparam int STAT_OORCH_LSB = 8;
   localparam int STAT_LP = 12;
   localparam int INT_OOR = 0;
   localparam int INT_SCAN = 1;
   localparam int INT_CONV = 2;
   localparam int INT_W = 3;
   localparam int RES_VALID = 31;
   localparam int RES_OOR = 30;

   // Reset values
   localparam logic [7:0] SMP_RST = 8'h04;
   localparam logic [11:0] LIM_LO_RST = 12'h000;
   localparam logic [11:0] LIM_HI_RST = 12'hfff;

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV} acs_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } acs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } acs_apb_rsp_t;

   typedef struct packed {
      logic [3:0] muxSel;
      logic sampleEn;
      logic convEn;
      logic sarClkEn;
      logic tempSensEn;
   } acs_sar_ctl_t;

   typedef struct packed {
      acs_state_t st;
      logic [3:0] ch;
      logic [7:0] cnt;
      logic [DIV_W-1:0] div;
      logic run;
      logic fwMode;
      logic fwPend;
      logic [3:0] fwCh;
      logic [NUM_CH-1:0] chEn;
      logic [RES_W-1:0] lowLim;
      logic [RES_W-1:0] highLim;
      logic [INT_W-1:0] intStat;
      logic [INT_W-1:0] intMask;
      logic [3:0] oorCh;
      logic [NUM_CH-1:0] resValid;
      logic [NUM_CH-1:0] resOor;
      logic [NUM_CH-1:0][RES_W-1:0] result;
      logic [NUM_CH-1:0][7:0] smpTime;
      logic [31:0] prdata;
      logic pslverr;
   } acs_regs_t;

   localparam acs_regs_t REGS_RST = '{
      st: ST_IDLE,
      lowLim: LIM_LO_RST,
      highLim: LIM_HI_RST,
      smpTime: {NUM_CH{SMP_RST}},
      default: '0
   };

   // First enabled channel after cur, wrapping past the highest one
   function automatic logic [3:0] acs_next_ch(input logic [NUM_CH-1:0] en,
                                              input logic [3:0] cur);
      logic [3:0] res;
      int k;
      res = cur;
      k = 0;
      for (int i = NUM_CH; i >= 1; i--) begin
         k = (int'(cur) + i) % NUM_CH;
         if (en[k]) begin
            res = 4'(k);
         end
      end
      return res;
   endfunction

   // Sample phase length in cycles is the programmed value, never less than one
   function automatic logic [7:0] acs_smp_load(input logic [7:0] t);
      return (t == 8'h00) ? 8'h00 : t - 8'h01;
   endfunction

endpackage

/* File: rtl/acs_adc_channel_sequencer.sv */
// ADC input sequencer with per-channel sample times, result buffers and range check
`timescale 1ns/1ps

// Operation
// - Converter input selector offers eight pin channels.
// - Once started, enabled channels are scanned with no processor action.
// - Next channel's sampling starts right after a conversion, no idle cycles.
// - Channel choice comes from the internal scanner or from firmware.
// - Every channel has its own result buffer.
// - Every channel has its own programmable sample time.
// - Low and high limits; a value outside them raises an interrupt.
// - The range check is made as each conversion completes.
// - The temperature sensor is a selectable input source.
// - Converter and sequencer are unavailable in the deep low-power modes.
// - A conversion takes at least eighteen converter clocks.
module acs_adc_channel_sequencer
   import acs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire acs_apb_req_t apbReq,
   output acs_apb_rsp_t apbRsp,
   input wire logic lowPower,
   input wire logic [RES_W-1:0] sarData,
   output acs_sar_ctl_t sarCtl,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // State
   acs_regs_t r;
   acs_regs_t next_r;

   logic setupPh;
   logic wrAcc;
   logic rdAcc;
   logic hiZero;
   logic [5:0] aIdx;
   logic isRes;
   logic isSmp;
   logic [3:0] resSel;
   logic [3:0] smpSel;
   logic sarTick;
   logic convDone;
   logic outRange;
   logic scanOn;
   logic [3:0] scanNext;
   logic [INT_W-1:0] intSet;
   logic [INT_W-1:0] intClr;
   logic [31:0] rdMux;
   logic mapped;

   assign setupPh = apbReq.psel && !apbReq.penable;
   assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign rdAcc = apbReq.psel && apbReq.penable && !apbReq.pwrite;
   assign hiZero = (apbReq.paddr[11:8] == 4'h0) && (apbReq.paddr[1:0] == 2'h0);
   assign aIdx = apbReq.paddr[7:2];
   assign isRes = hiZero && (aIdx >= RES_IDX) && (aIdx < RES_IDX + 6'(NUM_CH));
   assign isSmp = hiZero && (aIdx >= SMP_IDX) && (aIdx < SMP_IDX + 6'(NUM_CH));
   assign resSel = 4'(aIdx - RES_IDX);
   assign smpSel = 4'(aIdx - SMP_IDX);

   // Converter clock enable; restarted per conversion so its length is exact
   assign sarTick = (r.st == ST_CONV) && (r.div == DIV_MAX);
   assign convDone = sarTick && (r.cnt == 8'h00);
   assign outRange = (sarData < r.lowLim) || (sarData > r.highLim);
   assign scanOn = r.run && !r.fwMode;
   assign scanNext = acs_next_ch(r.chEn, r.ch);

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux, evaluated in the setup phase
   always_comb begin
      rdMux = 32'h0000_0000;
      mapped = 1'b1;
      if (isRes) begin
         rdMux[RES_W-1:0] = r.result[resSel];
         rdMux[RES_OOR] = r.resOor[resSel];
         rdMux[RES_VALID] = r.resValid[resSel];
      end else if (isSmp) begin
         rdMux[7:0] = r.smpTime[smpSel];
      end else if (apbReq.paddr == CTRL_OFS) begin
         rdMux[CTRL_RUN] = r.run;
         rdMux[CTRL_FW] = r.fwMode;
         rdMux[CTRL_GO] = r.fwPend;
         rdMux[CTRL_FWCH_LSB +: 4] = r.fwCh;
      end else if (apbReq.paddr == CHEN_OFS) begin
         rdMux[NUM_CH-1:0] = r.chEn;
      end else if (apbReq.paddr == LIMIT_OFS) begin
         rdMux[RES_W-1:0] = r.lowLim;
         rdMux[LIM_HI_LSB +: RES_W] = r.highLim;
      end else if (apbReq.paddr == STATUS_OFS) begin
         rdMux[STAT_BUSY] = (r.st != ST_IDLE);
         rdMux[STAT_CH_LSB +: 4] = r.ch;
         rdMux[STAT_OORCH_LSB +: 4] = r.oorCh;
         rdMux[STAT_LP] = lowPower;
      end else if (apbReq.paddr == INTSTAT_OFS) begin
         rdMux[INT_W-1:0] = r.intStat;
      end else if (apbReq.paddr == INTMASK_OFS) begin
         rdMux[INT_W-1:0] = r.intMask;
      end else begin
         mapped = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_r = r;
      intSet = '0;
      intClr = '0;

      if (setupPh) begin
         next_r.prdata = mapped ? rdMux : 32'h0000_0000;
         next_r.pslverr = !mapped;
      end

      // Register writes take effect at the access edge
      if (wrAcc && mapped) begin
         if (isSmp) begin
            next_r.smpTime[smpSel] = apbReq.pwdata[7:0];
         end else if (apbReq.paddr == CTRL_OFS) begin
            next_r.run = apbReq.pwdata[CTRL_RUN];
            next_r.fwMode = apbReq.pwdata[CTRL_FW];
            if (apbReq.pwdata[CTRL_GO]) begin
               next_r.fwPend = 1'b1;
            end
            if (apbReq.pwdata[CTRL_FWCH_LSB +: 4] <= TEMP_CH) begin
               next_r.fwCh = apbReq.pwdata[CTRL_FWCH_LSB +: 4];
            end
         end else if (apbReq.paddr == CHEN_OFS) begin
            next_r.chEn = apbReq.pwdata[NUM_CH-1:0];
         end else if (apbReq.paddr == LIMIT_OFS) begin
            next_r.lowLim = apbReq.pwdata[RES_W-1:0];
            next_r.highLim = apbReq.pwdata[LIM_HI_LSB +: RES_W];
         end else if (apbReq.paddr == INTSTAT_OFS) begin
            intClr = apbReq.pwdata[INT_W-1:0];
         end else if (apbReq.paddr == INTMASK_OFS) begin
            next_r.intMask = apbReq.pwdata[INT_W-1:0];
         end
      end

      // Reading a result consumes it; a new result in the same cycle keeps it valid
      if (rdAcc && isRes) begin
         next_r.resValid[resSel] = 1'b0;
      end

      // Sequencer
      next_r.div = (r.st == ST_CONV) ? ((r.div == DIV_MAX) ? '0 : r.div + 1'b1) : '0;
      unique case (r.st)
         ST_IDLE: begin
            if (r.fwMode && r.fwPend) begin
               // firmware-chosen channel, one conversion per go
               next_r.fwPend = 1'b0;
               next_r.ch = r.fwCh;
               next_r.st = ST_SAMPLE;
               next_r.cnt = acs_smp_load(r.smpTime[r.fwCh]);
            end else if (scanOn && (r.chEn != '0)) begin
               // scan always begins at the lowest enabled channel
               next_r.ch = acs_next_ch(r.chEn, 4'(NUM_CH - 1));
               next_r.st = ST_SAMPLE;
               next_r.cnt = acs_smp_load(r.smpTime[acs_next_ch(r.chEn, 4'(NUM_CH - 1))]);
            end
         end
         ST_SAMPLE: begin
            // hold sampling for this channel's time
            if (r.cnt == 8'h00) begin
               next_r.st = ST_CONV;
               next_r.cnt = CONV_CLKS - 8'h01;
            end else begin
               next_r.cnt = r.cnt - 8'h01;
            end
         end
         ST_CONV: begin
            // count full converter clocks before taking the result
            if (sarTick && (r.cnt != 8'h00)) begin
               next_r.cnt = r.cnt - 8'h01;
            end
            // A conversion cut short by low power leaves no result behind
            if (convDone && !lowPower) begin
               next_r.result[r.ch] = sarData;
               next_r.resValid[r.ch] = 1'b1;
               next_r.resOor[r.ch] = outRange;
               intSet[INT_CONV] = 1'b1;
               if (outRange) begin
                  intSet[INT_OOR] = 1'b1;
                  next_r.oorCh = r.ch;
               end
               if (scanOn && (r.chEn != '0)) begin
                  // straight into the next sample, no gap
                  next_r.ch = scanNext;
                  next_r.st = ST_SAMPLE;
                  next_r.cnt = acs_smp_load(r.smpTime[scanNext]);
                  if (scanNext <= r.ch) begin
                     intSet[INT_SCAN] = 1'b1;
                  end
               end else begin
                  next_r.st = ST_IDLE;
                  if (!r.fwMode) begin
                     intSet[INT_SCAN] = 1'b1;
                  end
               end
            end
         end
      endcase

      // no conversions while the fast clock is unavailable
      if (lowPower) begin
         next_r.st = ST_IDLE;
         next_r.cnt = 8'h00;
         next_r.fwPend = 1'b0;
      end

      // software write-one clears; a same-cycle event wins
      next_r.intStat = (r.intStat & ~intClr) | intSet;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= REGS_RST;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign apbRsp.prdata = r.prdata;
   assign apbRsp.pslverr = r.pslverr;
   assign apbRsp.pready = apbReq.psel && apbReq.penable;
   // selector spans eight pins plus the temperature sensor
   assign sarCtl.muxSel = r.ch;
   assign sarCtl.sampleEn = (r.st == ST_SAMPLE);
   assign sarCtl.convEn = (r.st == ST_CONV);
   assign sarCtl.sarClkEn = sarTick;
   assign sarCtl.tempSensEn = (r.st != ST_IDLE) && (r.ch == TEMP_CH);
   // level interrupt from unmasked sticky bits
   assign irq = |(r.intStat & r.intMask);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   localparam int CONV_REF = int'(CONV_CLKS) * SAR_DIV;
   logic [7:0] cnvLen;
   logic [7:0] smpLen;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnvLen <= 8'h00;
         smpLen <= 8'h00;
      end else begin
         cnvLen <= sarCtl.convEn ? cnvLen + 8'h01 : 8'h00;
         smpLen <= sarCtl.sampleEn ? smpLen + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_scan_done;
      convDone && scanOn && (r.chEn != '0) && !lowPower;
   endsequence

   sequence s_oor_done;
      convDone && outRange && !lowPower;
   endsequence

   AST_MUX_RANGE: assert property (sarCtl.muxSel <= TEMP_CH)
      else $error("channel select beyond last source");
   AST_NO_GAP: assert property (s_scan_done |=> sarCtl.sampleEn && !sarCtl.convEn)
      else $error("idle cycle between channels");
   AST_ASCEND: assert property (s_scan_done |=> sarCtl.muxSel == $past(scanNext))
      else $error("scan order wrong");
   AST_CONV_LEN: assert property (convDone |-> cnvLen == 8'(CONV_REF - 1))
      else $error("conversion length wrong");
   AST_SMP_LEN: assert property (sarCtl.sampleEn && r.cnt == 8'h00 |->
      smpLen == acs_smp_load(r.smpTime[r.ch]))
      else $error("sample time not per channel");
   AST_OOR_IRQ: assert property (s_oor_done |=> r.intStat[INT_OOR]
      && r.oorCh == $past(r.ch))
      else $error("out-of-range not flagged");
   AST_OOR_FAST: assert property ((s_oor_done and (r.intMask[INT_OOR] && !wrAcc))
      |=> irq)
      else $error("range interrupt delayed");
   AST_RESULT: assert property (convDone && !lowPower |=>
      r.result[$past(r.ch)] == $past(sarData) && r.resValid[$past(r.ch)])
      else $error("result not buffered");
   AST_STICKY: assert property (r.intStat[INT_OOR] && !(wrAcc
      && apbReq.paddr == INTSTAT_OFS) |=> r.intStat[INT_OOR])
      else $error("range flag lost without clear");
   AST_LOWPWR: assert property (lowPower |=> !sarCtl.sampleEn && !sarCtl.convEn)
      else $error("converting in low power");
   AST_FW_CH: assert property ($rose(sarCtl.sampleEn) && $past(r.fwMode) |->
      r.ch == $past(r.fwCh))
      else $error("firmware channel not used");
   AST_SCAN_START: assert property (r.st == ST_IDLE && scanOn && r.chEn != '0
      && !r.fwPend && !lowPower |=> sarCtl.sampleEn)
      else $error("scan did not start");

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencing and bookkeeping checks
   sequence s_last_done;
      convDone && !(scanOn && (r.chEn != '0)) && !lowPower;
   endsequence

   sequence s_wrap_done;
      s_scan_done ##0 (scanNext <= r.ch);
   endsequence

   sequence s_res_read;
      rdAcc && isRes && !(convDone && !lowPower && (r.ch == resSel));
   endsequence

   sequence s_fw_start;
      (r.st == ST_IDLE) && r.fwMode && r.fwPend && !lowPower;
   endsequence

   sequence s_oor_clear;
      wrAcc && (apbReq.paddr == INTSTAT_OFS) && apbReq.pwdata[INT_OOR];
   endsequence

   // Half-rate ticks keep the converter clock under its ceiling
   AST_TICK_GAP: assert property (sarCtl.sarClkEn |=> !sarCtl.sarClkEn)
      else $error("converter ticks too close");
   // The selector must not move while one channel is sampled or converted
   AST_MUX_HOLD: assert property (sarCtl.sampleEn || (sarCtl.convEn && !convDone) |=>
      $stable(sarCtl.muxSel))
      else $error("selector moved inside a conversion");
   AST_LAST_IDLE: assert property (s_last_done |=>
      !sarCtl.sampleEn && !sarCtl.convEn)
      else $error("sequencer kept going after its last conversion");
   AST_WRAP_IRQ: assert property (s_wrap_done |=> r.intStat[INT_SCAN])
      else $error("scan wrap not flagged");
   AST_FW_GO: assert property (s_fw_start |=> sarCtl.sampleEn && !r.fwPend
      && sarCtl.muxSel == $past(r.fwCh))
      else $error("firmware go not served once");
   AST_RD_CLEARS: assert property (s_res_read |=> !r.resValid[$past(resSel)])
      else $error("result read did not consume it");
   // A software clear with no new out-of-range event in the same cycle must drop the flag
   AST_W1C: assert property (s_oor_clear ##0 !(convDone && outRange && !lowPower) |=>
      !r.intStat[INT_OOR])
      else $error("range flag not cleared by software");

endmodule

/* File: tb/acs_sar_model.sv */
// Converter and analog source model facing the channel sequencer
`timescale 1ns/1ps
module acs_sar_model
   import acs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire acs_sar_ctl_t sarCtl,
   input wire logic [NUM_CH-1:0][RES_W-1:0] chanVal,
   output logic [RES_W-1:0] sarData
);
   logic [4:0] ticks;
   logic [RES_W-1:0] junk;

   ////////////////////////////////////////////////////////////////////////////////
   // eighteen converter ticks
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ticks <= '0;
         junk <= 12'h5a5;
      end else begin
         junk <= junk + 12'h3a7;
         if (sarCtl.convEn !== 1'b1) begin
            ticks <= '0;
         end else if (sarCtl.sarClkEn === 1'b1) begin
            ticks <= ticks + 5'h01;
         end
      end
   end

   // pins and temperature source
   // Outside the final tick the data bus churns so an early capture is caught
   assign sarData = (sarCtl.convEn && sarCtl.sarClkEn && ticks == 5'h11) ?
                    chanVal[sarCtl.muxSel] : junk;
endmodule

/* File: tb/acs_adc_channel_sequencer_tb.sv */
// Self-checking bench for the ADC channel sequencer
`timescale 1ns/1ps
module acs_adc_channel_sequencer_tb
   import acs_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic lowPower = 1'b0;
   acs_apb_req_t req = '0;
   acs_apb_rsp_t rsp;
   acs_sar_ctl_t sarCtl;
   logic irq;
   logic [RES_W-1:0] sarData;
   logic [NUM_CH-1:0][RES_W-1:0] chanVal;
   logic [NUM_CH-1:0][7:0] smpT;
   logic [NUM_CH-1:0] chMask;
   logic [11:0] lo;
   logic [11:0] hi;
   logic [31:0] q;
   logic e;
   logic monOn = 1'b0;
   logic sawTemp = 1'b0;
   logic prevSmp = 1'b0;
   logic prevConv = 1'b0;
   logic [3:0] lastCh = 4'h0;
   int err_count = 0;
   int n_tests = 0;
   int convCnt = 0;
   int smpCnt = 0;
   int tickCnt = 0;

   always #20 ref_clk = ~ref_clk;

   acs_adc_channel_sequencer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .apbReq(req),
      .apbRsp(rsp), .lowPower(lowPower), .sarData(sarData), .sarCtl(sarCtl), .irq(irq));

   acs_sar_model MDL (.ref_clk(ref_clk), .rst_n(rst_n), .sarCtl(sarCtl),
      .chanVal(chanVal), .sarData(sarData));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic hang(input string what);
      err_count++;
      $display("ERROR %0t: timed out waiting for %s", $time, what);
      close_out();
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      req.psel <= 1'b1;
      req.pwrite <= wr;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge ref_clk);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (rsp.pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         hang("pready");
      end
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         apb(1'b0, STATUS_OFS, 32'h0);
         k++;
      end while (q[STAT_BUSY] !== 1'b0 && k < 100);
      if (k >= 100) begin
         hang("idle");
      end
   endtask

   function automatic logic [3:0] nxt(input logic [NUM_CH-1:0] m, input logic [3:0] c);
      for (int i = 1; i <= NUM_CH; i++) begin
         if (m[(int'(c) + i) % NUM_CH]) begin
            return 4'((int'(c) + i) % NUM_CH);
         end
      end
      return c;
   endfunction

   function automatic logic [31:0] res_word(input logic [11:0] v);
      return {1'b1, (v < lo) || (v > hi), 18'h0, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Converter-side monitor, sampled where outputs have settled
   always @(negedge ref_clk) begin
      if (sarCtl.sampleEn === 1'b1 && !prevSmp && monOn && (convCnt > 0 || prevConv)) begin
         chk(32'(prevConv), 32'h1);
         chk(32'(sarCtl.muxSel), 32'(nxt(chMask, lastCh)));
      end
      if (sarCtl.sampleEn === 1'b1) begin
         smpCnt++;
      end else if (sarCtl.convEn !== 1'b1) begin
         smpCnt = 0;
      end
      if (sarCtl.convEn === 1'b1 && prevSmp) begin
         chk(smpCnt, (smpT[sarCtl.muxSel] == 8'h00) ? 1 : smpT[sarCtl.muxSel]);
         smpCnt = 0;
         tickCnt = 0;
         lastCh = sarCtl.muxSel;
      end
      if (sarCtl.sarClkEn === 1'b1) begin
         tickCnt++;
      end
      if (sarCtl.tempSensEn === 1'b1) begin
         sawTemp = 1'b1;
      end
      if (prevConv && sarCtl.convEn !== 1'b1) begin
         chk(tickCnt, 18);
         convCnt++;
      end
      prevSmp = (sarCtl.sampleEn === 1'b1);
      prevConv = (sarCtl.convEn === 1'b1);
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      hang("end of run");
   end

   initial begin
      void'($urandom(57273));
      lo = 12'($urandom_range(1, 12'h7ff));
      hi = 12'($urandom_range(12'h800, 12'hffe));
      for (int i = 0; i < NUM_CH; i++) begin
         chanVal[i] = 12'($urandom);
         smpT[i] = 8'($urandom_range(0, 6));
      end
      // Corner values: below, above and on both limits
      chanVal[0] = 12'h000;
      chanVal[1] = 12'hfff;
      chanVal[2] = lo;
      chanVal[3] = hi;
      chMask = 9'($urandom) | 9'h10f;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, LIMIT_OFS, 32'h0);
      chk(q, 32'h0fff0000);
      apb(1'b0, 12'h080, 32'h0);
      chk(q, 32'h4);
      apb(1'b0, 12'h0fc, 32'h0);
      chk(32'(e), 32'h1);
      $display("Test reset values done");

      for (int i = 0; i < NUM_CH; i++) begin
         apb(1'b1, 12'h080 + 12'(4 * i), 32'(smpT[i]));
      end
      apb(1'b1, LIMIT_OFS, {4'h0, hi, 4'h0, lo});
      apb(1'b1, CHEN_OFS, 32'(chMask));
      apb(1'b1, INTMASK_OFS, 32'h1);
      monOn = 1'b1;
      apb(1'b1, CTRL_OFS, 32'h1);
      for (int k = 0; convCnt < 1; k++) begin
         if (k > 500) hang("first conversion");
         @(posedge ref_clk);
      end
      @(negedge ref_clk);
      chk(32'(irq), 32'h1);
      for (int k = 0; convCnt < 2 * NUM_CH + 2; k++) begin
         if (k > 3000) hang("scan");
         @(posedge ref_clk);
      end
      apb(1'b1, CTRL_OFS, 32'h0);
      wait_idle();
      monOn = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (chMask[i]) begin
            apb(1'b0, 12'h040 + 12'(4 * i), 32'h0);
            chk(q, res_word(chanVal[i]));
         end
      end
      apb(1'b0, 12'h040, 32'h0);
      chk(32'(q[RES_VALID]), 32'h0);
      $display("Test autonomous scan done");

      apb(1'b0, INTSTAT_OFS, 32'h0);
      chk(q, 32'h7);
      apb(1'b1, INTMASK_OFS, 32'h0);
      @(negedge ref_clk);
      chk(32'(irq), 32'h0);
      apb(1'b1, INTSTAT_OFS, 32'h7);
      apb(1'b0, INTSTAT_OFS, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, INTMASK_OFS, 32'h7);
      @(negedge ref_clk);
      chk(32'(irq), 32'h0);
      $display("Test interrupt done");

      chanVal[8] <= ~chanVal[8];
      sawTemp = 1'b0;
      apb(1'b1, CTRL_OFS, 32'h86);
      wait_idle();
      chk(32'(sawTemp), 32'h1);
      apb(1'b0, 12'h060, 32'h0);
      chk(q, res_word(chanVal[8]));
      apb(1'b1, CTRL_OFS, 32'h92);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(32'(q[7:4]), 32'h8);
      $display("Test firmware mode done");

      smpT[0] = 8'h08;
      apb(1'b1, 12'h080, 32'h8);
      apb(1'b1, CTRL_OFS, 32'h06);
      @(posedge ref_clk);
      lowPower <= 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(32'({sarCtl.sampleEn, sarCtl.convEn}), 32'h0);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(32'({q[STAT_LP], q[STAT_BUSY]}), 32'h2);
      chk(32'(q[STAT_CH_LSB +: 4]), 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk(32'(q[RES_VALID]), 32'h0);
      lowPower <= 1'b0;
      $display("Test low power done");
      close_out();
   end
endmodule
